/* File: hdl/accel_pkg.sv */
// Purpose: Shared constants and types for the checksum and CRC accelerator
// Assumes: APB slave, 32-bit data, one register per aligned word
// Notes:   Printed offsets are register indices; byte address is four times the index
`default_nettype none

package accel_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [31:0] CFG_INDEX   = 32'h0000a078;
  localparam logic [31:0] DATA0_INDEX = 32'h0000a07c;
  localparam logic [31:0] DATA1_INDEX = 32'h0000a07d;
  localparam logic [31:0] DATA2_INDEX = 32'h0000a07e;
  localparam logic [31:0] DATA3_INDEX = 32'h0000a07f;
  localparam logic [31:0] ADDR_CFG    = CFG_INDEX * 32'h4;
  localparam logic [31:0] ADDR_DATA0  = DATA0_INDEX * 32'h4;
  localparam logic [31:0] ADDR_DATA1  = DATA1_INDEX * 32'h4;
  localparam logic [31:0] ADDR_DATA2  = DATA2_INDEX * 32'h4;
  localparam logic [31:0] ADDR_DATA3  = DATA3_INDEX * 32'h4;

  // ****************************************************************
  // Configuration fields and reset values
  // ****************************************************************
  localparam int          BUSY_BIT  = 0;
  localparam logic [7:0]  CFG_RESET = 8'h00;
  localparam logic [31:0] DATA_RESET = 32'h00000000;

  localparam logic [2:0] MODE_OFF   = 3'h0;
  localparam logic [2:0] MODE_CHK8  = 3'h1;
  localparam logic [2:0] MODE_CHK32 = 3'h2;
  localparam logic [2:0] MODE_CRC16A = 3'h3;
  localparam logic [2:0] MODE_CRC16B = 3'h4;
  localparam logic [2:0] MODE_CRC32 = 3'h5;
  localparam logic [2:0] MODE_RSVD  = 3'h6;
  localparam logic [2:0] MODE_CLEAR = 3'h7;

  localparam logic [1:0] WIDTH_8  = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_24 = 2'h2;
  localparam logic [1:0] WIDTH_32 = 2'h3;

  // ****************************************************************
  // Polynomials and default seeds
  // ****************************************************************
  localparam logic [31:0] POLY_CRC16A = 32'h00008005;
  localparam logic [31:0] POLY_CRC16B = 32'h00001021;
  localparam logic [31:0] POLY_CRC32  = 32'h04c11db7;
  localparam logic [31:0] SEED_CHK    = 32'h00000000;
  localparam logic [31:0] SEED_CRC16  = 32'h0000ffff;
  localparam logic [31:0] SEED_CRC32  = 32'hffffffff;
  localparam logic [31:0] MASK_8      = 32'h000000ff;
  localparam logic [31:0] MASK_16     = 32'h0000ffff;
  localparam logic [31:0] MASK_32     = 32'hffffffff;

  localparam int FIFO_DEPTH = 2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [1:0] width;          // Input width select
    logic       reverse;        // Mirror input bits
    logic       carry_discard;  // Drop checksum carry
    logic       seed;           // Data writes load seed
    logic [2:0] mode;           // Calculation mode
  } cfg_t;

  typedef struct packed {
    logic [31:0] word;          // Internal input word
    logic [1:0]  last_idx;      // Index of last byte
    logic        seed;          // Entry is a seed load
  } job_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CFG,
    SEL_D0,
    SEL_D1,
    SEL_D2,
    SEL_D3
  } sel_t;

endpackage : accel_pkg

`default_nettype wire

/* File: hdl/checksum_crc_accelerator.sv */
// Purpose: Checksum and CRC accelerator behind an APB slave
// Assumes: One clock pclk at 20 MHz, asynchronous active-low reset presetn
// Notes:   A two-entry job buffer sits between data entry and the byte engine
//          A lowest-byte write to a full buffer waits with pready low, no word is lost
//          Data reads show the calculation state, not the bytes last written
//          Mode is taken per byte as it is processed; change it only while idle
//          Mode 000 and the reserved code drain queued jobs without computing
//          Clear flushes queued jobs, the carry and the state in one cycle
//          Read data and error are captured in the setup cycle of a transfer
//          Low clock enable holds every flop and forces pready low
//
// Design decision made here: register access over APB.
`default_nettype none

module checksum_crc_accelerator (
  input  wire logic        pclk,     // System clock
  input  wire logic        presetn,  // Async reset, active low
  input  wire logic        ce,       // Clock enable, freezes all state
  input  wire logic        psel,     // APB select
  input  wire logic        penable,  // APB enable
  input  wire logic        pwrite,   // APB direction
  input  wire logic [31:0] paddr,    // APB byte address
  input  wire logic [31:0] pwdata,   // APB write data
  input  wire logic [3:0]  pstrb,    // APB write strobes
  output logic      [31:0] prdata,   // APB read data
  output logic             pready,   // APB ready
  output logic             pslverr   // APB error on unmapped address
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Address decode, used at setup and at access
  // An unmapped address gives SEL_NONE and so the error answer
  function automatic accel_pkg::sel_t decode(input logic [31:0] a);
    accel_pkg::sel_t s;
    s = accel_pkg::SEL_NONE;
    if (a == accel_pkg::ADDR_CFG) s = accel_pkg::SEL_CFG;
    if (a == accel_pkg::ADDR_DATA0) s = accel_pkg::SEL_D0;
    if (a == accel_pkg::ADDR_DATA1) s = accel_pkg::SEL_D1;
    if (a == accel_pkg::ADDR_DATA2) s = accel_pkg::SEL_D2;
    if (a == accel_pkg::ADDR_DATA3) s = accel_pkg::SEL_D3;
    return s;
  endfunction : decode

  // Mirror the low width bits of a word
  // Bits above the selected width stay zero
  function automatic logic [31:0] mirror(input logic [31:0] d, input logic [1:0] w);
    logic [31:0] r;
    r = 32'h00000000;
    for (int i = 0; i < 32; i++) begin
      if (i <= 8 * int'(w) + 7) begin
        r[i] = d[8 * int'(w) + 7 - i];
      end
    end
    return r;
  endfunction : mirror

  // Mask to the result width of a mode
  // Seeds are cut to it so stale upper bits never show
  function automatic logic [31:0] mode_mask(input logic [2:0] m);
    logic [31:0] r;
    r = accel_pkg::MASK_32;
    if (m == accel_pkg::MODE_CHK8) r = accel_pkg::MASK_8;
    if (m == accel_pkg::MODE_CRC16A || m == accel_pkg::MODE_CRC16B) r = accel_pkg::MASK_16;
    return r;
  endfunction : mode_mask

  // One byte through the CRC, input bit 0 first, no inversion
  // The 16-bit modes feed back from bit 15 and keep the upper half clear
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d,
                                           input logic is32, input logic [31:0] poly);
    logic [31:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = (is32 ? r[31] : r[15]) ^ d[i];
      r  = {r[30:0], 1'b0} ^ (fb ? poly : 32'h00000000);
      if (!is32) r[31:16] = 16'h0000;
    end
    return r;
  endfunction : crc_byte

  // ****************************************************************
  // Registers and wires
  // ****************************************************************
  // Stored configuration, input lanes and calculation state
  accel_pkg::cfg_t cfg_ff;
  logic [31:0]     in_ff;
  logic [31:0]     state_ff;
  logic            carry_ff;
  logic [1:0]      byte_idx_ff;

  // Job buffer storage and its pointers
  accel_pkg::job_t fifo_mem [accel_pkg::FIFO_DEPTH];
  logic            wr_ptr_ff;
  logic            rd_ptr_ff;
  logic [1:0]      count_ff;

  // Bus answer registers
  logic [31:0]     rdata_ff;
  logic            slverr_ff;

  // Bus decode and buffer handshake
  accel_pkg::sel_t sel_setup;
  accel_pkg::sel_t sel_acc;
  logic            access;
  logic            wr_take;
  logic            clear_cmd;
  logic            push_valid;
  logic            push_ready;
  logic            pop_valid;
  logic            pop_ready;

  // Engine side of the buffer
  accel_pkg::job_t head;
  accel_pkg::job_t push_job;
  logic [31:0]     entry_word;
  logic [7:0]      cur_byte;
  logic            last_byte;
  logic            busy;

  // Next state of the engine
  logic [31:0]     nxt_state;
  logic            nxt_carry;
  logic [32:0]     sum32;
  logic [8:0]      sum8;

  // ****************************************************************
  // APB decode and handshake
  // ****************************************************************
  // Decode, ready stalls a lowest-byte write while the buffer is full
  // Only byte lane 0 carries data; other strobes leave registers alone
  assign sel_setup  = decode(paddr);
  assign sel_acc    = decode(paddr);
  assign access     = psel && penable;
  assign push_valid = access && pwrite && pstrb[0] && (sel_acc == accel_pkg::SEL_D0);
  assign pready     = ce && !(push_valid && !push_ready);
  assign wr_take    = access && pwrite && pready;
  assign prdata     = rdata_ff;
  assign pslverr    = slverr_ff && access;
  assign clear_cmd  = wr_take && pstrb[0] && (sel_acc == accel_pkg::SEL_CFG)
                      && (pwdata[2:0] == accel_pkg::MODE_CLEAR);

  // Read data and error are captured in the setup cycle
  // Capturing early keeps prdata steady through any wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff  <= 32'h00000000;
      slverr_ff <= 1'b0;
    end else if (ce && psel && !penable) begin
      slverr_ff <= (sel_setup == accel_pkg::SEL_NONE);
      rdata_ff  <= 32'h00000000;
      unique case (sel_setup)
        accel_pkg::SEL_CFG: rdata_ff <= {24'h000000, cfg_ff[7:3], 2'b00, busy};
        accel_pkg::SEL_D0:  rdata_ff <= {24'h000000, state_ff[7:0]};
        accel_pkg::SEL_D1:  rdata_ff <= {24'h000000, state_ff[15:8]};
        accel_pkg::SEL_D2:  rdata_ff <= {24'h000000, state_ff[23:16]};
        accel_pkg::SEL_D3:  rdata_ff <= {24'h000000, state_ff[31:24]};
        accel_pkg::SEL_NONE: rdata_ff <= 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // Configuration register
  // ****************************************************************
  // Mode 111 clears state and pending jobs, previous mode is kept
  // Bits 7:3 are stored on every write, the clear code included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff <= accel_pkg::cfg_t'(accel_pkg::CFG_RESET);
    end else if (ce && wr_take && pstrb[0] && sel_acc == accel_pkg::SEL_CFG) begin
      cfg_ff[7:3] <= pwdata[7:3];
      if (pwdata[2:0] != accel_pkg::MODE_CLEAR) begin
        cfg_ff.mode <= pwdata[2:0];
      end
    end
  end

  // ****************************************************************
  // Input holding register
  // ****************************************************************
  // Bytes land in their own lanes of the entry word
  // Upper lanes are kept, so a narrow word may reuse them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_ff <= accel_pkg::DATA_RESET;
    end else if (ce && wr_take && pstrb[0]) begin
      if (sel_acc == accel_pkg::SEL_D0) in_ff[7:0]   <= pwdata[7:0];
      if (sel_acc == accel_pkg::SEL_D1) in_ff[15:8]  <= pwdata[7:0];
      if (sel_acc == accel_pkg::SEL_D2) in_ff[23:16] <= pwdata[7:0];
      if (sel_acc == accel_pkg::SEL_D3) in_ff[31:24] <= pwdata[7:0];
    end
  end

  // Lowest byte completes the word; seeds skip the mirror
  // Bytes above the selected width are masked before mirroring
  always_comb begin
    entry_word = {in_ff[31:8], pwdata[7:0]};
    unique case (cfg_ff.width)
      accel_pkg::WIDTH_8:  entry_word = entry_word & accel_pkg::MASK_8;
      accel_pkg::WIDTH_16: entry_word = entry_word & accel_pkg::MASK_16;
      accel_pkg::WIDTH_24: entry_word = entry_word & 32'h00ffffff;
      accel_pkg::WIDTH_32: entry_word = entry_word;
    endcase
    push_job.seed     = cfg_ff.seed;
    push_job.last_idx = cfg_ff.width;
    if (cfg_ff.seed) begin
      push_job.word = {in_ff[31:8], pwdata[7:0]};
    end else if (cfg_ff.reverse) begin
      push_job.word = mirror(entry_word, cfg_ff.width);
    end else begin
      push_job.word = entry_word;
    end
  end

  // ****************************************************************
  // Two-entry job buffer
  // ****************************************************************
  // Full and empty come straight from the entry count
  assign push_ready = (count_ff != 2'(accel_pkg::FIFO_DEPTH));
  assign pop_valid  = (count_ff != 2'h0);
  assign head       = fifo_mem[rd_ptr_ff];
  assign busy       = pop_valid;

  // Clear flushes pending jobs along with the state
  // A push and a pop in one cycle leave the count unchanged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_ff   <= 1'b0;
      rd_ptr_ff   <= 1'b0;
      count_ff    <= 2'h0;
      fifo_mem[0] <= '0;
      fifo_mem[1] <= '0;
    end else if (ce) begin
      if (clear_cmd) begin
        wr_ptr_ff <= 1'b0;
        rd_ptr_ff <= 1'b0;
        count_ff  <= 2'h0;
      end else begin
        if (push_valid && push_ready && wr_take) begin
          fifo_mem[wr_ptr_ff] <= push_job;
          wr_ptr_ff           <= !wr_ptr_ff;
        end
        if (pop_valid && pop_ready) begin
          rd_ptr_ff <= !rd_ptr_ff;
        end
        count_ff <= count_ff + 2'(push_valid && push_ready && wr_take) - 2'(pop_valid && pop_ready);
      end
    end
  end

  // ****************************************************************
  // Byte engine
  // ****************************************************************
  // Byte under work and end of the current job
  assign cur_byte  = head.word[8 * byte_idx_ff +: 8];
  assign last_byte = (byte_idx_ff == head.last_idx);
  assign pop_ready = head.seed || last_byte || (cfg_ff.mode == accel_pkg::MODE_OFF)
                     || (cfg_ff.mode == accel_pkg::MODE_RSVD) || (cfg_ff.mode == accel_pkg::MODE_CLEAR);

  // Next state for the byte at the head of the buffer
  // Off, reserved and clear codes leave the state as it is
  always_comb begin
    nxt_state = state_ff;
    nxt_carry = carry_ff;
    sum8      = 9'h000;
    sum32     = 33'h000000000;
    unique case (cfg_ff.mode)
      accel_pkg::MODE_CHK8: begin
        sum8      = {1'b0, state_ff[7:0]} + {1'b0, cur_byte}
                    + 9'(!cfg_ff.carry_discard && carry_ff);
        nxt_state = {24'h000000, sum8[7:0]};
        nxt_carry = sum8[8];
      end
      accel_pkg::MODE_CHK32: begin
        sum32     = {1'b0, state_ff} + {1'b0, 32'(cur_byte) << (8 * byte_idx_ff)}
                    + 33'(byte_idx_ff == 2'h0 && !cfg_ff.carry_discard && carry_ff);
        nxt_state = sum32[31:0];
        nxt_carry = (byte_idx_ff == 2'h0) ? sum32[32] : (carry_ff | sum32[32]);
      end
      accel_pkg::MODE_CRC16A: nxt_state = crc_byte(state_ff, cur_byte, 1'b0, accel_pkg::POLY_CRC16A);
      accel_pkg::MODE_CRC16B: nxt_state = crc_byte(state_ff, cur_byte, 1'b0, accel_pkg::POLY_CRC16B);
      accel_pkg::MODE_CRC32:  nxt_state = crc_byte(state_ff, cur_byte, 1'b1, accel_pkg::POLY_CRC32);
      default: nxt_state = state_ff;
    endcase
  end

  // Calculation state, one byte per enabled cycle
  // Off and reserved modes drop jobs without touching the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= accel_pkg::SEED_CHK;
      carry_ff    <= 1'b0;
      byte_idx_ff <= 2'h0;
    end else if (ce) begin
      // Clear takes the default seed of the mode in effect
      if (clear_cmd) begin
        carry_ff    <= 1'b0;
        byte_idx_ff <= 2'h0;
        if (cfg_ff.mode == accel_pkg::MODE_CRC16A || cfg_ff.mode == accel_pkg::MODE_CRC16B) begin
          state_ff <= accel_pkg::SEED_CRC16;
        end else if (cfg_ff.mode == accel_pkg::MODE_CRC32) begin
          state_ff <= accel_pkg::SEED_CRC32;
        end else begin
          state_ff <= accel_pkg::SEED_CHK;
        end
      end else if (pop_valid) begin
        if (cfg_ff.mode == accel_pkg::MODE_OFF || cfg_ff.mode == accel_pkg::MODE_RSVD) begin
          byte_idx_ff <= 2'h0;
        // A seed replaces the state and the carry in one cycle
        end else if (head.seed) begin
          state_ff    <= head.word & mode_mask(cfg_ff.mode);
          carry_ff    <= 1'b0;
          byte_idx_ff <= 2'h0;
        end else begin
          state_ff    <= nxt_state;
          carry_ff    <= nxt_carry;
          byte_idx_ff <= last_byte ? 2'h0 : byte_idx_ff + 2'h1;
        end
      end
    end
  end

endmodule : checksum_crc_accelerator

`default_nettype wire

/* File: verification/accel_properties.sv */
// Purpose: Port-level assertions for the accelerator
// Assumes: One clock pclk, async active-low presetn
// Notes:   Bound to the design top after the module
`default_nettype none

module accel_properties (
  input wire logic        pclk,     // Clock
  input wire logic        presetn,  // Reset, low
  input wire logic        ce,       // Clock enable
  input wire logic        psel,     // Select
  input wire logic        penable,  // Enable
  input wire logic        pwrite,   // Direction
  input wire logic [31:0] paddr,    // Address
  input wire logic [31:0] pwdata,   // Write data
  input wire logic [3:0]  pstrb,    // Strobes
  input wire logic [31:0] prdata,   // Read data
  input wire logic        pready,   // Ready
  input wire logic        pslverr   // Error
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       acc, okw, rdc, map;
  logic [4:0] cfg_ff;   // Stored config bits 7:3
  logic [2:0] mode_ff;  // Mode in effect
  logic [3:0] idle_ff;  // Enabled cycles since last push
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Decode of the access in progress
  assign acc = psel && penable;
  assign okw = acc && pready && pwrite && pstrb[0];
  assign rdc = acc && !pwrite && paddr == accel_pkg::ADDR_CFG;
  assign map = paddr == accel_pkg::ADDR_CFG || (paddr[1:0] == 2'h0 && paddr[31:4] == accel_pkg::ADDR_DATA0[31:4]);

  // Shadow of config writes; the clear code keeps the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff  <= 5'h00;
      mode_ff <= 3'h0;
    end else if (okw && paddr == accel_pkg::ADDR_CFG) begin
      cfg_ff  <= pwdata[7:3];
      mode_ff <= (pwdata[2:0] == 3'h7) ? mode_ff : pwdata[2:0];
    end
  end

  // Age of the newest job, frozen while disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_ff <= 4'hf;
    end else if (okw && paddr == accel_pkg::ADDR_DATA0) begin
      idle_ff <= 4'h0;
    end else if (ce && idle_ff != 4'hf) begin
      idle_ff <= idle_ff + 4'h1;
    end
  end

  a_err_unmapped: assert property (acc && !map && $past(ce) |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (acc && map && $past(ce) |-> !pslverr)
    else $error("mapped access flagged");
  a_rdata_byte: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data above byte lane");
  a_cfg_readback: assert property (rdc && $past(ce) |-> prdata[7:3] == cfg_ff && prdata[2:1] == 2'h0)
    else $error("config read differs");
  a_busy_on_push: assert property (rdc && $past(ce) && $past(idle_ff) <= 4'h1 && cfg_ff[4:3] == 2'h3
    && !cfg_ff[0] && !(mode_ff inside {3'h0, 3'h6}) |-> prdata[0]) else $error("busy low during job");
  a_busy_clears: assert property (rdc && $past(ce) && $past(idle_ff) >= 4'ha |-> !prdata[0])
    else $error("busy stuck high");
  a_no_wait: assert property (acc && ce && !(pwrite && paddr == accel_pkg::ADDR_DATA0) |-> pready)
    else $error("unexpected wait state");
  a_stall_ends: assert property (acc && ce && !pready |-> ##[1:9] pready)
    else $error("stall too long");
endmodule : accel_properties

bind checksum_crc_accelerator accel_properties accel_properties_i (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));

`default_nettype wire

/* File: verification/accel_cpu_model.sv */
// Purpose: CPU side of the register bus, an APB master
// Assumes: Signals change only after rising edges
// Notes:   Tasks are called from the bench
`default_nettype none

module accel_cpu_model (
  input  wire logic        pclk,     // Clock
  input  wire logic        pready,   // Ready
  input  wire logic [31:0] prdata,   // Read data
  input  wire logic        pslverr,  // Error
  output var  logic        psel,     // Select
  output var  logic        penable,  // Enable
  output var  logic        pwrite,   // Direction
  output var  logic [31:0] paddr,    // Address
  output var  logic [31:0] pwdata,   // Write data
  output var  logic [3:0]  pstrb     // Strobes
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end

  // One transfer, request held until pready is sampled high
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? wd : 32'h0;
    pstrb <= w ? 4'hf : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Enter a word: higher bytes first, lowest byte last
  task automatic put_word(input logic [31:0] word, input logic [1:0] w);
    logic [31:0] r;
    logic e;
    for (int k = 3; k > 0; k--) if (k <= int'(w)) xfer(1'b1, accel_pkg::ADDR_DATA0 + 32'(4 * k),
                                                      {24'h0, word[8*k +: 8]}, r, e);
    xfer(1'b1, accel_pkg::ADDR_DATA0, {24'h0, word[7:0]}, r, e);
  endtask : put_word
endmodule : accel_cpu_model

`default_nettype wire

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the checksum and CRC engine
// Assumes: 20 MHz pclk, fixed random seed
// Notes:   Sums are recomputed here word by word, CRCs bit by bit
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, ecy;
  logic [31:0] paddr, pwdata, prdata, est;
  logic [3:0]  pstrb;
  logic [7:0]  tcfg [8] = '{8'h01, 8'h31, 8'hc2, 8'hb2, 8'h03, 8'h64, 8'hc5, 8'hb5};
  int          err_total = 0, checked = 0, cyc = 0;

  checksum_crc_accelerator checksum_crc_accelerator_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  accel_cpu_model accel_cpu_model_i (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

  // Clock and hang guard
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp32

  function automatic logic [31:0] mode_mask(input logic [2:0] m);
    if (m == accel_pkg::MODE_CHK8) return accel_pkg::MASK_8;
    if (m == accel_pkg::MODE_CRC16A || m == accel_pkg::MODE_CRC16B) return accel_pkg::MASK_16;
    return accel_pkg::MASK_32;
  endfunction : mode_mask

  // Config write, and result read once busy has dropped
  task automatic wcfg(input logic [7:0] v);
    logic [31:0] d;
    logic e;
    accel_cpu_model_i.xfer(1'b1, accel_pkg::ADDR_CFG, {24'h0, v}, d, e);
  endtask : wcfg
  task automatic get_res(output logic [31:0] res);
    logic [31:0] d;
    logic e;
    int n;
    n = 0;
    do begin
      accel_cpu_model_i.xfer(1'b0, accel_pkg::ADDR_CFG, 32'h0, d, e);
      n++;
    end while (d[accel_pkg::BUSY_BIT] !== 1'b0 && n < 20);
    for (int k = 0; k < 4; k++) begin
      accel_cpu_model_i.xfer(1'b0, accel_pkg::ADDR_DATA0 + 32'(4 * k), 32'h0, d, e);
      res[8*k +: 8] = d[7:0];
    end
  endtask : get_res

  // Expected effect of one entered word
  task automatic ref_word(input logic [31:0] raw, input logic [7:0] c);
    logic [31:0] x, poly;
    logic [32:0] s;
    logic        fb;
    int          nb;
    nb = 8 * (int'(c[7:6]) + 1);
    x = 32'h0;
    for (int i = 0; i < nb; i++) x[i] = c[5] ? raw[nb - 1 - i] : raw[i];
    s = {32'h0, ecy && !c[4]};
    poly = (c[2:0] == 3'h3) ? accel_pkg::POLY_CRC16A : (c[2:0] == 3'h4) ? accel_pkg::POLY_CRC16B : accel_pkg::POLY_CRC32;
    if (c[2:0] == accel_pkg::MODE_CHK8) begin
      s = s + est[7:0] + x[7:0];
      est = {24'h0, s[7:0]};
      ecy = s[8];
    end else if (c[2:0] == accel_pkg::MODE_CHK32) begin
      s = s + est + x;
      est = s[31:0];
      ecy = s[32];
    end else begin
      for (int i = 0; i < nb; i++) begin
        fb = est[(c[2:0] == 3'h5) ? 31 : 15] ^ x[i];
        est = ({est[30:0], 1'b0} ^ (fb ? poly : 32'h0)) & mode_mask(c[2:0]);
      end
    end
  endtask : ref_word

  // Main sequence
  initial begin
    logic [31:0] r, word;
    logic [7:0]  c;
    logic        e;
    presetn = 1'b0;
    ce = 1'b1;
    ecy = 1'b0;
    void'($urandom(21393));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    accel_cpu_model_i.xfer(1'b0, accel_pkg::ADDR_CFG, 32'h0, r, e);
    cmp32("config", {24'h0, accel_pkg::CFG_RESET}, r);
    get_res(r);
    cmp32("data", accel_pkg::DATA_RESET, r);
    foreach (tcfg[t]) begin
      c = tcfg[t];
      wcfg(c | 8'h08);
      word = $urandom & mode_mask(c[2:0]) & (32'hffffffff >> (8 * (3 - int'(c[7:6]))));
      accel_cpu_model_i.put_word(word, accel_pkg::WIDTH_32);
      est = word;
      ecy = 1'b0;
      wcfg(c);
      get_res(r);
      cmp32("seed", est, r);
      for (int j = 0; j < 8; j++) begin
        word = (j == 0) ? 32'hffffffff : (j < 4) ? $urandom : {word[31:8], 8'($urandom)};
        accel_cpu_model_i.put_word(word, (j < 4) ? c[7:6] : accel_pkg::WIDTH_8);
        ref_word(word, c);
      end
      if (t == 6) begin
        ce <= 1'b0;
        repeat (3) @(posedge pclk);
        ce <= 1'b1;
      end
      get_res(r);
      cmp32("result", est, r);
      wcfg({c[7:3], accel_pkg::MODE_CLEAR});
      est = (c[2:0] >= accel_pkg::MODE_CRC16A) ? mode_mask(c[2:0]) : accel_pkg::SEED_CHK;
      ecy = 1'b0;
      get_res(r);
      cmp32("cleared", est, r);
      word = $urandom;
      accel_cpu_model_i.put_word(word, c[7:6]);
      ref_word(word, c);
      get_res(r);
      cmp32("after clear", est, r);
      wcfg({c[7:3], t[0] ? accel_pkg::MODE_RSVD : accel_pkg::MODE_OFF});
      accel_cpu_model_i.put_word($urandom, c[7:6]);
      get_res(r);
      cmp32("disabled", est, r);
      $display("test %0d config %h done", t, c);
    end
    accel_cpu_model_i.xfer(1'b0, accel_pkg::ADDR_CFG + 32'h4, 32'h0, r, e);
    cmp32("unmapped data", 32'h0, r);
    cmp32("unmapped error", 32'h1, {31'h0, e});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    accel_cpu_model_i.xfer(1'b0, accel_pkg::ADDR_CFG, 32'h0, r, e);
    cmp32("config", {24'h0, accel_pkg::CFG_RESET}, r);
    summarize();
  end
endmodule : tb

`default_nettype wire
